/* logic/sla_alu.sv */
`default_nettype none
module sla_alu
  import sla_pkg::*;
(
  input  wire logic [3:0] op,
  input  wire logic [1:0] dst,
  input  wire logic       src,
  input  wire logic [2:0] bitn,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] imm,
  input  wire logic [7:0] mem,
  input  wire logic [7:0] io,
  input  wire logic       cin,
  input  wire logic       io_out,
  input  wire logic       pin,
  output logic      [7:0] res,
  output logic            cout,
  output logic            z_upd,
  output logic            legal
);
  always_comb
  begin
    logic [7:0] opd;
    logic [7:0] sec;
    opd   = (dst == DST_MEM) ? mem : ((dst == DST_IO) ? io : acc);
    sec   = (dst == DST_ACC) ? ((src == SRC_MEM) ? mem : imm) : acc;
    res   = opd;
    cout  = cin;
    z_upd = 1'b0;
    legal = (dst != DST_IO);
    case (op)
      OP_SHR_ZF: begin res = {1'b0, opd[7:1]}; cout = opd[0]; end
      OP_SHR_RC: begin res = {cin, opd[7:1]}; cout = opd[0]; end
      OP_SHL_ZF: begin res = {opd[6:0], 1'b0}; cout = opd[7]; end
      OP_SHL_RC: begin res = {opd[6:0], cin}; cout = opd[7]; end
      OP_NIB_X:
      begin
        res   = {opd[3:0], opd[7:4]};
        legal = (dst == DST_ACC);
      end
      OP_AND:    begin res = opd & sec; z_upd = 1'b1; end
      OP_OR:     begin res = opd | sec; z_upd = 1'b1; end
      OP_XOR:
      begin
        res   = opd ^ sec;
        z_upd = (dst != DST_IO);
        legal = 1'b1;
      end
      OP_NOT:    begin res = ~opd; z_upd = 1'b1; end
      OP_NEG:    begin res = 8'h00 - opd; z_upd = 1'b1; end
      OP_BCLR:   begin res = opd & ~bit_mask(bitn); legal = (dst != DST_ACC); end
      OP_BSET:   begin res = opd | bit_mask(bitn); legal = (dst != DST_ACC); end
      OP_CBX:
      begin
        res   = cin ? (opd | bit_mask(bitn)) : (opd & ~bit_mask(bitn));
        cout  = io_out ? opd[bitn] : pin;
        legal = (dst == DST_IO);
      end
      default:   legal = 1'b0;
    endcase
  end
endmodule : sla_alu
`default_nettype wire

/* logic/sla_pkg.sv */
`default_nettype none
package sla_pkg;
  localparam int         SLA_W        = 8;
  // Operation codes from the instruction decoder
  localparam logic [3:0] OP_SHR_ZF    = 4'h0;
  localparam logic [3:0] OP_SHR_RC    = 4'h1;
  localparam logic [3:0] OP_SHL_ZF    = 4'h2;
  localparam logic [3:0] OP_SHL_RC    = 4'h3;
  localparam logic [3:0] OP_NIB_X     = 4'h4;
  localparam logic [3:0] OP_AND       = 4'h5;
  localparam logic [3:0] OP_OR        = 4'h6;
  localparam logic [3:0] OP_XOR       = 4'h7;
  localparam logic [3:0] OP_NOT       = 4'h8;
  localparam logic [3:0] OP_NEG       = 4'h9;
  localparam logic [3:0] OP_BCLR      = 4'ha;
  localparam logic [3:0] OP_BSET      = 4'hb;
  localparam logic [3:0] OP_CBX       = 4'hc;
  // Destination and second-operand selects
  localparam logic [1:0] DST_ACC      = 2'h0;
  localparam logic [1:0] DST_MEM      = 2'h1;
  localparam logic [1:0] DST_IO       = 2'h2;
  localparam logic       SRC_IMM      = 1'h0;
  localparam logic       SRC_MEM      = 1'h1;
  // Flag register layout
  localparam int         FLAG_Z_BIT   = 0;
  localparam int         FLAG_C_BIT   = 1;
  localparam int         FLAG_AUX_BIT = 2;
  localparam int         FLAG_OVF_BIT = 3;
  localparam logic [3:0] FLAG_RST     = 4'h0;
  localparam logic [7:0] ACC_RST      = 8'h00;
  localparam logic [5:0] FLAG_IO_ADDR = 6'h00;
  // Register offsets on the bus
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ACC      = 8'h04;
  localparam logic [7:0] REG_FLAGS    = 8'h08;
  localparam logic [7:0] REG_LAST     = 8'h0c;
  localparam logic [7:0] REG_OPCNT    = 8'h10;
  localparam logic [7:0] REG_ERRCNT   = 8'h14;
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         CTRL_CLR_BIT = 1;
  localparam logic       CTRL_EN_RST  = 1'h1;
  localparam logic [2:0] HSIZE_WORD   = 3'h2;

  function automatic logic [7:0] bit_mask(input logic [2:0] n);
    bit_mask = 8'h01 << n;
  endfunction : bit_mask
endpackage : sla_pkg
`default_nettype wire

/* logic/sla_top.sv */
`default_nettype none
module sla_top
  import sla_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int MEM_AW = 7,
  parameter int CNT_W  = 16
)
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire logic              OP_VALID,
  input  wire logic [3:0]        OP_CODE,
  input  wire logic [1:0]        OP_DST,
  input  wire logic              OP_SRC,
  input  wire logic [2:0]        OP_BIT,
  input  wire logic [7:0]        OP_IMM,
  input  wire logic [MEM_AW-1:0] OP_MEM_ADDR,
  input  wire logic [5:0]        OP_IO_ADDR,
  input  wire logic [7:0]        MEM_RDATA,
  input  wire logic [7:0]        IO_RDATA,
  input  wire logic              IO_BIT_IS_OUT,
  input  wire logic              IO_PIN_LEVEL,
  output logic                   OP_DONE,
  output logic                   OP_ERROR,
  output logic                   MEM_WE,
  output logic      [MEM_AW-1:0] MEM_WADDR,
  output logic      [7:0]        MEM_WDATA,
  output logic                   IO_WE,
  output logic      [5:0]        IO_WADDR,
  output logic      [7:0]        IO_WDATA,
  output logic      [7:0]        ACC_OUT,
  output logic      [3:0]        FLAG_OUT
);
  if (DATA_W != SLA_W) begin : g_bad_width
    $error("Datapath width must be 8");
  end
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("Counter width must be 1 to 32");
  end

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  logic [7:0]       acc;
  logic [3:0]       flags;
  logic [3:0]       next_flags;
  logic             carry;
  logic             ctrl_en;
  logic [7:0]       last_res;
  logic [CNT_W-1:0] op_cnt;
  logic [CNT_W-1:0] err_cnt;
  logic             flag_hit;
  logic [7:0]       io_src;
  logic [7:0]       res;
  logic             cout;
  logic             z_upd;
  logic             legal;
  logic             op_take;
  logic             exec;
  logic             bus_take;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             bus_wr;
  logic             clr_cnt;
  logic [31:0]      rd_mux;

  assign carry    = flags[FLAG_C_BIT];
  assign flag_hit = (OP_IO_ADDR == FLAG_IO_ADDR);
  assign io_src   = flag_hit ? {4'h0, flags} : IO_RDATA;
  // Disabled block drops requests; the decoder must not rely on them
  assign op_take  = OP_VALID && ctrl_en;
  assign exec     = op_take && legal;

  sla_alu u_alu (
    .op     (OP_CODE),
    .dst    (OP_DST),
    .src    (OP_SRC),
    .bitn   (OP_BIT),
    .acc    (acc),
    .imm    (OP_IMM),
    .mem    (MEM_RDATA),
    .io     (io_src),
    .cin    (carry),
    .io_out (IO_BIT_IS_OUT),
    .pin    (IO_PIN_LEVEL),
    .res    (res),
    .cout   (cout),
    .z_upd  (z_upd),
    .legal  (legal)
  );

  // Bus slave: zero wait, always OKAY, word accesses only
  assign bus_take  = HSEL && HTRANS[1] && HREADY && (HSIZE == HSIZE_WORD);
  assign bus_wr    = wr_pend;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign clr_cnt   = bus_wr && reg_hit(wr_addr, REG_CTRL) && HWDATA[CTRL_CLR_BIT];

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= bus_take && HWRITE;
      wr_addr <= bus_take ? HADDR[7:0] : wr_addr;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(HADDR[7:0], REG_CTRL))
      rd_mux[CTRL_EN_BIT] = ctrl_en;
    else if (reg_hit(HADDR[7:0], REG_ACC))
      rd_mux[7:0] = acc;
    else if (reg_hit(HADDR[7:0], REG_FLAGS))
      rd_mux[3:0] = flags;
    else if (reg_hit(HADDR[7:0], REG_LAST))
      rd_mux[7:0] = last_res;
    else if (reg_hit(HADDR[7:0], REG_OPCNT))
      rd_mux[CNT_W-1:0] = op_cnt;
    else if (reg_hit(HADDR[7:0], REG_ERRCNT))
      rd_mux[CNT_W-1:0] = err_cnt;
  end

  // Read data snapshot at the address phase, held through data phase
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      HRDATA <= 32'h0000_0000;
    else if (bus_take && !HWRITE)
      HRDATA <= rd_mux;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      ctrl_en <= CTRL_EN_RST;
    else if (bus_wr && reg_hit(wr_addr, REG_CTRL))
      ctrl_en <= HWDATA[CTRL_EN_BIT];
  end

  // Operation beats a bus write to the same register in one cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      acc <= ACC_RST;
    else if (exec && OP_DST == DST_ACC)
      acc <= res;
    else if (bus_wr && reg_hit(wr_addr, REG_ACC))
      acc <= HWDATA[7:0];
  end

  always_comb
  begin
    next_flags = flags;
    if (exec)
    begin
      // carry is the only shift flag
      next_flags[FLAG_C_BIT] = cout;
      if (z_upd)
        next_flags[FLAG_Z_BIT] = (res == 8'h00);
      // bit ops land in flag register
      if (OP_DST == DST_IO && flag_hit)
        next_flags = res[3:0];
    end
    else if (bus_wr && reg_hit(wr_addr, REG_FLAGS))
      next_flags = HWDATA[3:0];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      flags <= FLAG_RST;
    else
      flags <= next_flags;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      MEM_WE    <= 1'b0;
      MEM_WADDR <= '0;
      MEM_WDATA <= 8'h00;
    end
    else
    begin
      MEM_WE <= exec && (OP_DST == DST_MEM);
      if (exec && OP_DST == DST_MEM)
      begin
        MEM_WADDR <= OP_MEM_ADDR;
        MEM_WDATA <= res;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      IO_WE    <= 1'b0;
      IO_WADDR <= 6'h00;
      IO_WDATA <= 8'h00;
    end
    else
    begin
      IO_WE <= exec && (OP_DST == DST_IO) && !flag_hit;
      if (exec && OP_DST == DST_IO && !flag_hit)
      begin
        IO_WADDR <= OP_IO_ADDR;
        IO_WDATA <= res;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      OP_DONE  <= 1'b0;
      OP_ERROR <= 1'b0;
      last_res <= 8'h00;
    end
    else
    begin
      OP_DONE  <= exec;
      OP_ERROR <= op_take && !legal;
      if (exec)
        last_res <= res;
    end
  end

  // Counters wrap; a count in the clear cycle survives as one
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      op_cnt  <= '0;
      err_cnt <= '0;
    end
    else
    begin
      if (clr_cnt)
        op_cnt <= exec ? CNT_W'(1) : '0;
      else if (exec)
        op_cnt <= op_cnt + CNT_W'(1);
      if (clr_cnt)
        err_cnt <= (op_take && !legal) ? CNT_W'(1) : '0;
      else if (op_take && !legal)
        err_cnt <= err_cnt + CNT_W'(1);
    end
  end

  assign ACC_OUT  = acc;
  assign FLAG_OUT = flags;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_op(logic [3:0] c, logic [1:0] d);
    exec && OP_CODE == c && OP_DST == d;
  endsequence

  sequence s_cbx(logic dir);
    exec && OP_CODE == OP_CBX && !flag_hit && IO_BIT_IS_OUT == dir;
  endsequence

  AST_SHR_ZF: assert property (
    s_op(OP_SHR_ZF, DST_ACC) |=>
      acc == ($past(acc) >> 1) && carry == |($past(acc) & 8'h01))
    else $error("Right zero-fill shift wrong");

  AST_SHR_RC: assert property (
    s_op(OP_SHR_RC, DST_MEM) |=> MEM_WE &&
      MEM_WDATA == (($past(MEM_RDATA) >> 1) | ($past(carry) ? 8'h80 : 8'h00)) &&
      carry == |($past(MEM_RDATA) & 8'h01))
    else $error("Right rotate through carry wrong");

  AST_SHL_ZF: assert property (
    s_op(OP_SHL_ZF, DST_ACC) |=>
      acc == ($past(acc) << 1) && carry == |($past(acc) & 8'h80))
    else $error("Left zero-fill shift wrong");

  AST_SHL_RC: assert property (
    s_op(OP_SHL_RC, DST_ACC) |=>
      acc == (($past(acc) << 1) | ($past(carry) ? 8'h01 : 8'h00)))
    else $error("Left rotate through carry wrong");

  AST_SHIFT_FLAGS: assert property (
    exec && OP_CODE <= OP_SHL_RC |=> (flags & 4'hd) == ($past(flags) & 4'hd))
    else $error("Shift touched a flag other than carry");

  AST_SWAP: assert property (
    s_op(OP_NIB_X, DST_ACC) |=>
      acc == (($past(acc) << 4) | ($past(acc) >> 4)) && $stable(flags))
    else $error("Nibble exchange wrong");

  AST_ZERO: assert property (
    exec && z_upd |=> flags[FLAG_Z_BIT] == (last_res == 8'h00) && $stable(carry) &&
      flags[FLAG_AUX_BIT] == $past(flags[FLAG_AUX_BIT]))
    else $error("Zero flag not tied to result");

  AST_XOR_IO: assert property (
    s_op(OP_XOR, DST_IO) ##0 !flag_hit |=> IO_WE && $stable(flags) &&
      IO_WDATA == ($past(acc) ^ $past(IO_RDATA)))
    else $error("I/O XOR wrong or changed a flag");

  AST_NEG: assert property (
    s_op(OP_NEG, DST_MEM) |=> MEM_WE && $stable(carry) &&
      MEM_WDATA == 8'h00 - $past(MEM_RDATA))
    else $error("Negate wrong");

  AST_BITOP: assert property (
    s_op(OP_BSET, DST_MEM) |=> MEM_WE && $stable(flags) &&
      MEM_WDATA == ($past(MEM_RDATA) | bit_mask($past(OP_BIT))))
    else $error("Bit set on memory wrong");

  AST_CBX_IN: assert property (
    s_cbx(1'b0) |=> carry == $past(IO_PIN_LEVEL) && IO_WE &&
      (flags & 4'hd) == ($past(flags) & 4'hd))
    else $error("Carry exchange on input pin wrong");

  AST_CBX_OUT: assert property (
    s_cbx(1'b1) |=> ((IO_WDATA & bit_mask($past(OP_BIT))) != 8'h00) == $past(carry))
    else $error("Carry exchange on output bit wrong");

  AST_FLAG_C: assert property (
    s_op(OP_BSET, DST_IO) ##0 (flag_hit && OP_BIT == 3'(FLAG_C_BIT)) |=> carry && !IO_WE)
    else $error("Bit set on flag register missed carry");

  AST_ONE_CYCLE: assert property (
    op_take |=> (OP_DONE ^ OP_ERROR) ##1 !OP_DONE || $past(op_take))
    else $error("Operation not finished in one cycle");
endmodule : sla_top
`default_nettype wire

/* verification/sla_core_model.sv */
`default_nettype none
module sla_core_model
#(
  parameter int MEM_AW = 7
)
(
  input  wire logic              clk,
  input  wire logic [MEM_AW-1:0] rd_addr,
  input  wire logic [5:0]        io_rd_addr,
  input  wire logic              mem_we,
  input  wire logic [MEM_AW-1:0] mem_waddr,
  input  wire logic [7:0]        mem_wdata,
  input  wire logic              io_we,
  input  wire logic [5:0]        io_waddr,
  input  wire logic [7:0]        io_wdata,
  output logic      [7:0]        mem_rdata,
  output logic      [7:0]        io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [2**MEM_AW];
  logic [7:0] io  [64];
  // Flow-through read: the operand must be there at the edge that takes the op
  assign mem_rdata = mem[rd_addr];
  assign io_rdata  = io[io_rd_addr];
  always @(posedge clk)
  begin
    if (mem_we)
    begin
      mem[mem_waddr] <= mem_wdata;
    end
    if (io_we)
    begin
      io[io_waddr] <= io_wdata;
    end
  end
endmodule : sla_core_model
`default_nettype wire

/* verification/tb_shift_logic_bit_alu.sv */
`default_nettype none
module tb_shift_logic_bit_alu
  import sla_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] MA = 7'h05;
  logic        SYS_CLK, RST_N, HSEL, HWRITE, HRESP, HREADYOUT, OP_VALID, OP_SRC;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS, OP_DST;
  logic [2:0]  HSIZE, OP_BIT;
  logic [3:0]  OP_CODE, FLAG_OUT;
  logic [7:0]  OP_IMM, MEM_RDATA, IO_RDATA, MEM_WDATA, IO_WDATA, ACC_OUT;
  logic [6:0]  MEM_WADDR;
  logic [5:0]  OP_IO_ADDR, IO_WADDR;
  logic        IO_BIT_IS_OUT, IO_PIN_LEVEL, OP_DONE, OP_ERROR, MEM_WE, IO_WE;
  int          n_fail, checked;
  logic [31:0] rd;

  sla_top #(.MEM_AW(7)) sla_top_inst (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_DST(OP_DST), .OP_SRC(OP_SRC), .OP_BIT(OP_BIT),
    .OP_IMM(OP_IMM), .OP_MEM_ADDR(MA), .OP_IO_ADDR(OP_IO_ADDR), .MEM_RDATA(MEM_RDATA),
    .IO_RDATA(IO_RDATA), .IO_BIT_IS_OUT(IO_BIT_IS_OUT), .IO_PIN_LEVEL(IO_PIN_LEVEL),
    .OP_DONE(OP_DONE), .OP_ERROR(OP_ERROR), .MEM_WE(MEM_WE), .MEM_WADDR(MEM_WADDR),
    .MEM_WDATA(MEM_WDATA), .IO_WE(IO_WE), .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA),
    .ACC_OUT(ACC_OUT), .FLAG_OUT(FLAG_OUT));

  sla_core_model #(.MEM_AW(7)) sla_core_model_inst (
    .clk(SYS_CLK), .rd_addr(MA), .io_rd_addr(OP_IO_ADDR), .mem_we(MEM_WE),
    .mem_waddr(MEM_WADDR), .mem_wdata(MEM_WDATA), .io_we(IO_WE), .io_waddr(IO_WADDR),
    .io_wdata(IO_WDATA), .mem_rdata(MEM_RDATA), .io_rdata(IO_RDATA));

  initial
  begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  task automatic give_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // Waits for hready at a rising edge; a bus that never answers ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      give_verdict();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= wr;
    HSIZE  <= HSIZE_WORD;
    wait_rdy();
    HTRANS <= 2'h0;
    HSEL   <= 1'b0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
  endtask : bus

  task automatic issue(input logic [3:0] op, input logic [1:0] dst, input logic src,
                       input logic [2:0] bn, input logic [7:0] imm);
    @(posedge SYS_CLK);
    OP_VALID <= 1'b1;
    OP_CODE  <= op;
    OP_DST   <= dst;
    OP_SRC   <= src;
    OP_BIT   <= bn;
    OP_IMM   <= imm;
    @(posedge SYS_CLK);
    OP_VALID <= 1'b0;
    #1;
  endtask : issue

  // One op from a known accumulator, flags and operand; result checked one cycle on
  task automatic tc(input logic [3:0] op, input logic [1:0] dst, input logic src,
                    input logic [2:0] bn, input logic [7:0] imm, input logic [7:0] acc,
                    input logic [3:0] flg, input logic [7:0] opnd, input logic isout,
                    input logic pin, input logic [7:0] res, input logic [3:0] eflg);
    bus(1'b1, REG_ACC, {24'h0, acc});
    bus(1'b1, REG_FLAGS, {28'h0, flg});
    sla_core_model_inst.mem[MA] = opnd;
    sla_core_model_inst.io[OP_IO_ADDR] = opnd;
    IO_BIT_IS_OUT <= isout;
    IO_PIN_LEVEL  <= pin;
    issue(op, dst, src, bn, imm);
    // Bit operations aimed at the accumulator are the only refused forms used here
    chk(32'({OP_DONE, OP_ERROR}), (dst == DST_ACC && op >= OP_BCLR) ? 32'h1 : 32'h2);
    chk(32'(FLAG_OUT), 32'(eflg));
    if (dst == DST_ACC)
      chk(32'(ACC_OUT), 32'(res));
    else if (dst == DST_MEM)
      chk(32'({MEM_WE, MEM_WADDR, MEM_WDATA}), 32'({1'b1, MA, res}));
    else
      chk(32'({IO_WE, IO_WADDR, IO_WDATA}), 32'({1'b1, OP_IO_ADDR, res}));
  endtask : tc

  initial
  begin
    n_fail = 0;
    checked = 0;
    RST_N = 1'b0;
    {HSEL, HWRITE, OP_VALID, OP_SRC, IO_BIT_IS_OUT, IO_PIN_LEVEL} = '0;
    {HADDR, HWDATA} = '0;
    HTRANS = 2'h0;
    HSIZE = HSIZE_WORD;
    {OP_CODE, OP_DST, OP_BIT, OP_IMM} = '0;
    OP_IO_ADDR = 6'h21;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(32'(HRESP), 32'h0);
    bus(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    tc(OP_SHR_ZF, DST_ACC, 0, 0, 0, 8'h81, 4'hc, 8'h00, 0, 0, 8'h40, 4'he);
    tc(OP_SHR_ZF, DST_MEM, 0, 0, 0, 8'h00, 4'hc, 8'h01, 0, 0, 8'h00, 4'he);
    tc(OP_SHR_RC, DST_ACC, 0, 0, 0, 8'h02, 4'h2, 8'h00, 0, 0, 8'h81, 4'h0);
    tc(OP_SHR_RC, DST_MEM, 0, 0, 0, 8'h00, 4'h1, 8'h01, 0, 0, 8'h00, 4'h3);
    tc(OP_SHL_ZF, DST_ACC, 0, 0, 0, 8'h81, 4'h0, 8'h00, 0, 0, 8'h02, 4'h2);
    tc(OP_SHL_ZF, DST_MEM, 0, 0, 0, 8'h00, 4'h3, 8'h7f, 0, 0, 8'hfe, 4'h1);
    tc(OP_SHL_RC, DST_ACC, 0, 0, 0, 8'h80, 4'h2, 8'h00, 0, 0, 8'h01, 4'h2);
    tc(OP_SHL_RC, DST_MEM, 0, 0, 0, 8'h00, 4'h2, 8'h40, 0, 0, 8'h81, 4'h0);
    tc(OP_NIB_X, DST_ACC, 0, 0, 0, 8'ha5, 4'hf, 8'h00, 0, 0, 8'h5a, 4'hf);
    tc(OP_AND, DST_ACC, SRC_IMM, 0, 8'h0f, 8'hf0, 4'he, 8'hff, 0, 0, 8'h00, 4'hf);
    tc(OP_AND, DST_ACC, SRC_MEM, 0, 8'hff, 8'h3c, 4'h1, 8'hf0, 0, 0, 8'h30, 4'h0);
    tc(OP_AND, DST_MEM, 0, 0, 0, 8'h3c, 4'h3, 8'hf0, 0, 0, 8'h30, 4'h2);
    tc(OP_OR, DST_ACC, SRC_IMM, 0, 8'h00, 8'h00, 4'he, 8'h55, 0, 0, 8'h00, 4'hf);
    tc(OP_OR, DST_MEM, 0, 0, 0, 8'h0f, 4'h1, 8'h30, 0, 0, 8'h3f, 4'h0);
    tc(OP_XOR, DST_ACC, SRC_MEM, 0, 0, 8'h55, 4'h2, 8'h55, 0, 0, 8'h00, 4'h3);
    tc(OP_XOR, DST_MEM, 0, 0, 0, 8'hff, 4'hf, 8'h0f, 0, 0, 8'hf0, 4'he);
    tc(OP_XOR, DST_IO, 0, 0, 0, 8'h33, 4'he, 8'h33, 0, 0, 8'h00, 4'he);
    tc(OP_NOT, DST_ACC, 0, 0, 0, 8'h38, 4'h1, 8'h00, 0, 0, 8'hc7, 4'h0);
    tc(OP_NOT, DST_MEM, 0, 0, 0, 8'h00, 4'h2, 8'hff, 0, 0, 8'h00, 4'h3);
    tc(OP_NEG, DST_ACC, 0, 0, 0, 8'h38, 4'hc, 8'h00, 0, 0, 8'hc8, 4'hc);
    tc(OP_NEG, DST_MEM, 0, 0, 0, 8'h01, 4'h2, 8'h00, 0, 0, 8'h00, 4'h3);
    tc(OP_BCLR, DST_IO, 0, 7, 0, 8'h00, 4'hf, 8'hff, 0, 0, 8'h7f, 4'hf);
    tc(OP_BSET, DST_IO, 0, 0, 0, 8'h00, 4'h0, 8'h00, 0, 0, 8'h01, 4'h0);
    tc(OP_BCLR, DST_MEM, 0, 3, 0, 8'h00, 4'h5, 8'hff, 0, 0, 8'hf7, 4'h5);
    tc(OP_BSET, DST_MEM, 0, 6, 0, 8'h00, 4'ha, 8'h00, 0, 0, 8'h40, 4'ha);
    tc(OP_CBX, DST_IO, 0, 2, 0, 8'h00, 4'h0, 8'h04, 1, 0, 8'h00, 4'h2);
    // Latch bit and pin differ so that only the pin can clear the carry
    tc(OP_CBX, DST_IO, 0, 2, 0, 8'h00, 4'he, 8'h04, 0, 0, 8'h04, 4'hc);
    @(posedge SYS_CLK);
    OP_IO_ADDR <= FLAG_IO_ADDR;
    tc(OP_BSET, DST_ACC, 0, 0, 0, 8'h5a, 4'h3, 8'h00, 0, 0, 8'h5a, 4'h3);
    chk(32'(OP_ERROR), 32'h1);
    bus(1'b1, REG_FLAGS, 32'h0);
    issue(OP_BSET, DST_IO, 0, 3'(FLAG_C_BIT), 0);
    chk(32'({IO_WE, FLAG_OUT}), 32'h2);
    issue(OP_BCLR, DST_IO, 0, 3'(FLAG_C_BIT), 0);
    chk(32'({IO_WE, FLAG_OUT}), 32'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    issue(OP_NOT, DST_ACC, 0, 0, 0);
    chk(32'({OP_DONE, ACC_OUT}), 32'h05a);
    bus(1'b1, REG_CTRL, 32'h1);
    issue(OP_NOT, DST_ACC, 0, 0, 0);
    chk(32'({OP_DONE, ACC_OUT}), 32'h1a5);
    bus(1'b0, REG_LAST, 32'h0);
    chk(rd, 32'ha5);
    // Thirty accepted operations and one refused one so far
    bus(1'b0, REG_OPCNT, 32'h0);
    chk(rd, 32'h1e);
    bus(1'b0, REG_ERRCNT, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, REG_CTRL, 32'h3);
    bus(1'b0, REG_OPCNT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, REG_ACC, 32'h0);
    chk(rd, 32'ha5);
    give_verdict();
  end
endmodule : tb_shift_logic_bit_alu
`default_nettype wire
